// ### common/exc_vec_pkg.sv
// shared constants and carrier types for the exception vector and fault rerun unit
package exc_vec_pkg;

  localparam int VEC_W = 8;
  localparam int ADDR_W = 32;
  localparam int OFFSET_SHIFT = 2;

  localparam logic [7:0] VEC_RESET_SP = 8'h00;
  localparam logic [7:0] VEC_RESET_PC = 8'h01;
  localparam logic [7:0] VEC_BUS_ERROR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERROR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] VEC_BOUNDS_CHECK = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV_VIOL = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_LINE_A = 8'h0A;
  localparam logic [7:0] VEC_LINE_F = 8'h0B;
  localparam logic [7:0] VEC_HW_BKPT = 8'h0C;
  localparam logic [7:0] VEC_FORMAT_ERR = 8'h0E;
  localparam logic [7:0] VEC_UNINIT_INT = 8'h0F;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTOVEC_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_USER_FIRST = 8'h40;

  localparam logic [4:0] MOVE_OPERANDS_MAX = 5'h10;

  // function codes of the two spaces the table lives in
  localparam logic [2:0] FC_SUPERVISOR_DATA = 3'h5;
  localparam logic [2:0] FC_SUPERVISOR_PROGRAM = 3'h6;

  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // special status word bit positions
  localparam int SSW_RERUN_POS = 12;
  localparam int SSW_READ_POS = 6;
  localparam int SSW_SIZE_LSB = 4;
  localparam int SSW_FC_LSB = 0;

  typedef enum logic [3:0] {
    CAUSE_NONE, CAUSE_BUS_ERROR, CAUSE_ADDR_ERROR, CAUSE_ILLEGAL, CAUSE_ZERO_DIV,
    CAUSE_BOUNDS_CHECK, CAUSE_COND_TRAP, CAUSE_PRIV_VIOL, CAUSE_TRACE, CAUSE_LINE_A,
    CAUSE_LINE_F, CAUSE_HW_BKPT, CAUSE_FORMAT_ERR, CAUSE_UNINIT_INT, CAUSE_INTERRUPT,
    CAUSE_TRAP
  } cause_type;

  // request from the sequencer to start exception processing
  typedef struct packed {
    logic valid;
    cause_type cause;
    logic [3:0] trap_num;
    logic [2:0] int_level;
    logic autovector;
    logic spurious;
    logic [7:0] ext_vector;
  } exc_req_type;

  // bus fetch request issued by this unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [2:0] fc;
    logic [1:0] size;
    logic write;
  } bus_req_type;

  // bus completion from the bus controller
  typedef struct packed {
    logic done;
    logic berr;
    logic [31:0] rdata;
  } bus_rsp_type;

  // state saved when a cycle faults
  typedef struct packed {
    logic [15:0] special_status_word;
    logic [31:0] fault_addr;
    logic [31:0] move_next_addr;
    logic [4:0] move_remaining;
  } fault_frame_type;

endpackage

// ### design/exc_vec_unit.sv
// exception vectoring, reset fetch and faulted cycle rerun
`timescale 1ns/10ps

// Notes on behaviour
// - at reset fetch stack pointer from vector 0, offset 0x000, supervisor program space
// - then fetch program counter from vector 1, offset 0x004, supervisor program space
// - fixed vectors 2 to 15 in supervisor data space; vector 13 unused
// - spurious interrupt is vector 24; autovectors 25 to 31 for levels 1 to 7
// - trap instructions 0 to 15 use vectors 32 to 47
// - vectors 64 to 255 user defined; external vectors are passed unchecked
// - interrupt acknowledge with no arbitration answer ends in internal bus error
// - rerun decision on return uses only the rerun-required bit
// - rerun takes address and size from stacked fault address and size field
// - a rerun read is performed and its returned data discarded
// - restartable faults unstack state, then refetch and restart the instruction
// - multiple register move fault saves next address and remaining count
module exc_vec_unit (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire exc_vec_pkg::exc_req_type exc_req,
  input wire logic iack_active,
  input wire logic iack_arb_seen,
  input wire logic rte_req,
  input wire logic rte_restart,
  input wire exc_vec_pkg::fault_frame_type stacked_frame,
  input wire logic fault_capture,
  input wire exc_vec_pkg::fault_frame_type live_frame,
  input wire exc_vec_pkg::bus_rsp_type bus_rsp,
  output exc_vec_pkg::bus_req_type bus_req,
  output logic iack_berr,
  output logic [31:0] init_sp,
  output logic [31:0] init_pc,
  output logic reset_done,
  output logic [31:0] vector_word,
  output logic vector_valid,
  output logic [7:0] vector_num,
  output logic rerun_done,
  output logic restart_fetch,
  output exc_vec_pkg::fault_frame_type saved_frame
);

  typedef enum logic [2:0] {ST_SP, ST_PC, ST_IDLE, ST_VEC, ST_RERUN} state_type;

  state_type state_q, state_d;
  exc_vec_pkg::bus_req_type bus_q, bus_d;
  logic [31:0] sp_q, sp_d, pc_q, pc_d, vw_q, vw_d;
  logic [7:0] vn_q, vn_d, vec_sel;
  logic rd_q, rd_d, vv_q, vv_d, rr_q, rr_d, rf_q, rf_d, be_q, be_d;
  // restart wish kept over the rerun, rte_restart only stands with rte_req
  logic rs_q, rs_d;
  exc_vec_pkg::fault_frame_type fr_q, fr_d;

  // cause to vector number
  always_comb
  begin
    case (exc_req.cause)
      exc_vec_pkg::CAUSE_BUS_ERROR: vec_sel = exc_vec_pkg::VEC_BUS_ERROR;
      exc_vec_pkg::CAUSE_ADDR_ERROR: vec_sel = exc_vec_pkg::VEC_ADDR_ERROR;
      exc_vec_pkg::CAUSE_ILLEGAL: vec_sel = exc_vec_pkg::VEC_ILLEGAL;
      exc_vec_pkg::CAUSE_ZERO_DIV: vec_sel = exc_vec_pkg::VEC_ZERO_DIV;
      exc_vec_pkg::CAUSE_BOUNDS_CHECK: vec_sel = exc_vec_pkg::VEC_BOUNDS_CHECK;
      exc_vec_pkg::CAUSE_COND_TRAP: vec_sel = exc_vec_pkg::VEC_COND_TRAP;
      exc_vec_pkg::CAUSE_PRIV_VIOL: vec_sel = exc_vec_pkg::VEC_PRIV_VIOL;
      exc_vec_pkg::CAUSE_TRACE: vec_sel = exc_vec_pkg::VEC_TRACE;
      exc_vec_pkg::CAUSE_LINE_A: vec_sel = exc_vec_pkg::VEC_LINE_A;
      exc_vec_pkg::CAUSE_LINE_F: vec_sel = exc_vec_pkg::VEC_LINE_F;
      exc_vec_pkg::CAUSE_HW_BKPT: vec_sel = exc_vec_pkg::VEC_HW_BKPT;
      exc_vec_pkg::CAUSE_FORMAT_ERR: vec_sel = exc_vec_pkg::VEC_FORMAT_ERR;
      exc_vec_pkg::CAUSE_UNINIT_INT: vec_sel = exc_vec_pkg::VEC_UNINIT_INT;
      exc_vec_pkg::CAUSE_TRAP: vec_sel = exc_vec_pkg::VEC_TRAP_BASE + {4'h0, exc_req.trap_num};
      exc_vec_pkg::CAUSE_INTERRUPT:
      begin
        if (exc_req.spurious)
          vec_sel = exc_vec_pkg::VEC_SPURIOUS;
        else if (exc_req.autovector)
          vec_sel = exc_vec_pkg::VEC_AUTOVEC_BASE + {5'h00, exc_req.int_level};
        else
          vec_sel = exc_req.ext_vector;
      end
      default: vec_sel = exc_vec_pkg::VEC_UNINIT_INT;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    bus_d = bus_q;
    sp_d = sp_q;
    pc_d = pc_q;
    vw_d = vw_q;
    vn_d = vn_q;
    rd_d = rd_q;
    vv_d = 1'b0;
    rr_d = 1'b0;
    rf_d = 1'b0;
    rs_d = rs_q;
    fr_d = fr_q;
    // only the iack phase may raise this, never a vector fetch
    be_d = iack_active && !iack_arb_seen;
    if (fault_capture)
      fr_d = live_frame;
    case (state_q)
      ST_SP:
      begin
        bus_d = '{1'b1, {22'h0, exc_vec_pkg::VEC_RESET_SP, 2'h0}, exc_vec_pkg::FC_SUPERVISOR_PROGRAM,
          exc_vec_pkg::SIZE_LONG, 1'b0};
        if (bus_q.valid && bus_rsp.done)
        begin
          sp_d = bus_rsp.rdata;
          bus_d.addr = {22'h0, exc_vec_pkg::VEC_RESET_PC, 2'h0};
          state_d = ST_PC;
        end
      end
      ST_PC:
      begin
        if (bus_rsp.done)
        begin
          pc_d = bus_rsp.rdata;
          rd_d = 1'b1;
          bus_d.valid = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (exc_req.valid)
        begin
          vn_d = vec_sel;
          bus_d = '{1'b1, {22'h0, vec_sel, 2'h0}, exc_vec_pkg::FC_SUPERVISOR_DATA, exc_vec_pkg::SIZE_LONG, 1'b0};
          state_d = ST_VEC;
        end
        else if (rte_req && stacked_frame.special_status_word[exc_vec_pkg::SSW_RERUN_POS])
        begin
          bus_d.valid = 1'b1;
          bus_d.addr = stacked_frame.fault_addr;
          bus_d.size = stacked_frame.special_status_word[exc_vec_pkg::SSW_SIZE_LSB +: 2];
          bus_d.fc = stacked_frame.special_status_word[exc_vec_pkg::SSW_FC_LSB +: 3];
          bus_d.write = !stacked_frame.special_status_word[exc_vec_pkg::SSW_READ_POS];
          rs_d = rte_restart;
          state_d = ST_RERUN;
        end
        else if (rte_req && rte_restart)
          rf_d = 1'b1;
      end
      ST_VEC:
      begin
        if (bus_rsp.done)
        begin
          vw_d = bus_rsp.rdata;
          vv_d = 1'b1;
          bus_d.valid = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_RERUN:
      begin
        // read data is not captured anywhere
        if (bus_rsp.done)
        begin
          bus_d.valid = 1'b0;
          rr_d = 1'b1;
          rf_d = rs_q;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_SP;
      bus_q <= '0;
      sp_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      vw_q <= 32'h0000_0000;
      vn_q <= 8'h00;
      rd_q <= 1'b0;
      vv_q <= 1'b0;
      rr_q <= 1'b0;
      rf_q <= 1'b0;
      rs_q <= 1'b0;
      be_q <= 1'b0;
      fr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      bus_q <= bus_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      vw_q <= vw_d;
      vn_q <= vn_d;
      rd_q <= rd_d;
      vv_q <= vv_d;
      rr_q <= rr_d;
      rf_q <= rf_d;
      rs_q <= rs_d;
      be_q <= be_d;
      fr_q <= fr_d;
    end
  end

  assign bus_req = bus_q;
  assign iack_berr = be_q;
  assign init_sp = sp_q;
  assign init_pc = pc_q;
  assign reset_done = rd_q;
  assign vector_word = vw_q;
  assign vector_valid = vv_q;
  assign vector_num = vn_q;
  assign rerun_done = rr_q;
  assign restart_fetch = rf_q;
  assign saved_frame = fr_q;

  a_reset_sp_fetch: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_SP && bus_q.valid) |-> (bus_q.addr == 32'h0 && bus_q.fc == exc_vec_pkg::FC_SUPERVISOR_PROGRAM))
    else $error("sp fetch wrong");
  a_reset_pc_fetch: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_PC) |-> (bus_q.addr == 32'h4 && bus_q.fc == exc_vec_pkg::FC_SUPERVISOR_PROGRAM))
    else $error("pc fetch wrong");
  a_vec_offset_x4: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_VEC) |-> (bus_q.addr == {22'h0, vn_q, 2'h0} && bus_q.size == exc_vec_pkg::SIZE_LONG))
    else $error("vector offset wrong");
  a_trap_vector_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_IDLE && exc_req.valid && exc_req.cause == exc_vec_pkg::CAUSE_TRAP)
      |=> (vn_q == 8'h20 + {4'h0, $past(exc_req.trap_num)}))
    else $error("trap vector wrong");
  a_autovec_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_IDLE && exc_req.valid && exc_req.cause == exc_vec_pkg::CAUSE_INTERRUPT
      && exc_req.autovector && !exc_req.spurious) |=> (vn_q == 8'h18 + {5'h0, $past(exc_req.int_level)}))
    else $error("autovector wrong");
  a_iack_berr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (iack_active && !iack_arb_seen) |=> iack_berr)
    else $error("iack berr missing");
  a_rerun_only_rr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_IDLE && !exc_req.valid && rte_req) |=>
      ((state_q == ST_RERUN) == $past(stacked_frame.special_status_word[exc_vec_pkg::SSW_RERUN_POS])))
    else $error("rerun decision wrong");
  a_rerun_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_IDLE && !exc_req.valid && rte_req && stacked_frame.special_status_word[exc_vec_pkg::SSW_RERUN_POS])
      |=> (bus_q.addr == $past(stacked_frame.fault_addr)))
    else $error("rerun address wrong");
  a_read_discard: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_RERUN) |=> $stable(vw_q))
    else $error("rerun read data kept");
  a_frame_capture: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fault_capture |=> (saved_frame == $past(live_frame)))
    else $error("fault frame not saved");
  a_restart_fetch: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == ST_IDLE && !exc_req.valid && rte_req && rte_restart
      && !stacked_frame.special_status_word[exc_vec_pkg::SSW_RERUN_POS]) |=> restart_fetch)
    else $error("restart missing");

  c_reset_done: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(reset_done));
  c_vector_read: cover property (@(posedge sys_clk) disable iff (!arst_n) vector_valid);
  c_rerun_write: cover property (@(posedge sys_clk) disable iff (!arst_n) state_q == ST_RERUN && bus_q.write);
  c_iack_berr: cover property (@(posedge sys_clk) disable iff (!arst_n) iack_berr);

endmodule // exc_vec_unit

// ### verif/bus_ctrl_model.sv
// behavioural bus controller answering the unit's fetches
`timescale 1ns/10ps
module bus_ctrl_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire exc_vec_pkg::bus_req_type bus_req,
  input wire logic [3:0] lat,
  output exc_vec_pkg::bus_rsp_type bus_rsp
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  exc_vec_pkg::bus_rsp_type rsp_d;

  function automatic logic [31:0] pattern(input logic [31:0] a);
    return {~a[15:0], a[15:0] ^ 16'h5AC3};
  endfunction

  // data lines change every idle cycle so a stale word is never mistaken
  always_comb
  begin
    cnt_d = 4'h0;
    rsp_d = '{1'b0, 1'b0, ~bus_rsp.rdata};
    if (bus_req.valid && !bus_rsp.done)
    begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == lat)
      begin
        rsp_d.done = 1'b1;
        rsp_d.rdata = pattern(bus_req.addr);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 4'h0;
      bus_rsp <= '{1'b0, 1'b0, 32'hA5A5_A5A5};
    end
    else
    begin
      cnt_q <= cnt_d;
      bus_rsp <= rsp_d;
    end
  end
endmodule // bus_ctrl_model

// ### verif/exc_vec_unit_test.sv
// self-checking bench for the exception vector and fault rerun unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module exc_vec_unit_test;
  logic sys_clk;
  logic arst_n;
  exc_vec_pkg::exc_req_type exc_req;
  logic iack_active;
  logic iack_arb_seen;
  logic rte_req;
  logic rte_restart;
  exc_vec_pkg::fault_frame_type stacked_frame;
  logic fault_capture;
  exc_vec_pkg::fault_frame_type live_frame;
  exc_vec_pkg::bus_rsp_type bus_rsp;
  exc_vec_pkg::bus_req_type bus_req;
  logic iack_berr;
  logic [31:0] init_sp;
  logic [31:0] init_pc;
  logic reset_done;
  logic [31:0] vector_word;
  logic vector_valid;
  logic [7:0] vector_num;
  logic rerun_done;
  logic restart_fetch;
  exc_vec_pkg::fault_frame_type saved_frame;
  logic [3:0] lat;
  int error_cnt;
  int check_count;
  logic [7:0] fixed_vec [13] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
    8'h0C, 8'h0E, 8'h0F};

  exc_vec_unit u_dut (.sys_clk, .arst_n, .exc_req, .iack_active, .iack_arb_seen, .rte_req, .rte_restart,
    .stacked_frame, .fault_capture, .live_frame, .bus_rsp, .bus_req, .iack_berr, .init_sp, .init_pc,
    .reset_done, .vector_word, .vector_valid, .vector_num, .rerun_done, .restart_fetch, .saved_frame);
  bus_ctrl_model u_bus (.sys_clk, .arst_n, .bus_req, .lat, .bus_rsp);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // waits bounded so a silent design ends in a mismatch, not a hang
  task automatic expect_req(input logic [31:0] a, input logic [2:0] fc, input logic [1:0] sz, input logic wr);
    int n;
    n = 0;
    while (bus_req.valid !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("req valid", 1'b1, bus_req.valid)
    `CHK("req addr", a, bus_req.addr)
    `CHK("req space", fc, bus_req.fc)
    `CHK("req size", sz, bus_req.size)
    `CHK("req write", wr, bus_req.write)
    n = 0;
    while (bus_rsp.done !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("req answered", 1'b1, bus_rsp.done)
    @(negedge sys_clk);
  endtask

  task automatic test_reset;
    lat = 4'h2;
    expect_req(32'h0, exc_vec_pkg::FC_SUPERVISOR_PROGRAM, exc_vec_pkg::SIZE_LONG, 1'b0);
    `CHK("init sp", u_bus.pattern(32'h0), init_sp)
    expect_req(32'h4, exc_vec_pkg::FC_SUPERVISOR_PROGRAM, exc_vec_pkg::SIZE_LONG, 1'b0);
    `CHK("init pc", u_bus.pattern(32'h4), init_pc)
    `CHK("reset done", 1'b1, reset_done)
    `CHK("bus idle", 1'b0, bus_req.valid)
    $display("reset fetch test done");
  endtask

  task automatic run_vec(input exc_vec_pkg::exc_req_type r, input logic [7:0] v);
    @(posedge sys_clk);
    exc_req <= r;
    @(posedge sys_clk);
    exc_req.valid <= 1'b0;
    @(negedge sys_clk);
    expect_req({22'h0, v, 2'h0}, exc_vec_pkg::FC_SUPERVISOR_DATA, exc_vec_pkg::SIZE_LONG, 1'b0);
    `CHK("vec valid", 1'b1, vector_valid)
    `CHK("vec num", v, vector_num)
    `CHK("vec word", u_bus.pattern({22'h0, v, 2'h0}), vector_word)
  endtask

  task automatic test_vectors;
    for (int i = 1; i < 14; i++)
    begin
      lat = 4'(i % 3);
      run_vec('{1'b1, exc_vec_pkg::cause_type'(i), 4'h0, 3'h0, 1'b0, 1'b0, 8'h00}, fixed_vec[i - 1]);
    end
    for (int l = 1; l < 8; l++)
      run_vec('{1'b1, exc_vec_pkg::CAUSE_INTERRUPT, 4'h0, 3'(l), 1'b1, 1'b0, 8'h00}, 8'(8'h18 + l));
    run_vec('{1'b1, exc_vec_pkg::CAUSE_INTERRUPT, 4'h0, 3'h3, 1'b0, 1'b1, 8'h00}, 8'h18);
    for (int t = 0; t < 16; t++)
      run_vec('{1'b1, exc_vec_pkg::CAUSE_TRAP, 4'(t), 3'h0, 1'b0, 1'b0, 8'h00}, 8'(8'h20 + t));
    // external vectors go through unchecked, even processor-defined ones
    run_vec('{1'b1, exc_vec_pkg::CAUSE_INTERRUPT, 4'h0, 3'h2, 1'b0, 1'b0, 8'h40}, 8'h40);
    run_vec('{1'b1, exc_vec_pkg::CAUSE_INTERRUPT, 4'h0, 3'h2, 1'b0, 1'b0, 8'hFF}, 8'hFF);
    run_vec('{1'b1, exc_vec_pkg::CAUSE_INTERRUPT, 4'h0, 3'h2, 1'b0, 1'b0, 8'h05}, 8'h05);
    $display("vector table test done");
  endtask

  task automatic test_iack;
    `CHK("berr idle", 1'b0, iack_berr)
    @(posedge sys_clk);
    iack_active <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("berr unanswered", 1'b1, iack_berr)
    @(posedge sys_clk);
    iack_arb_seen <= 1'b1;
    @(negedge sys_clk);
    `CHK("berr holds", 1'b1, iack_berr)
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("berr answered", 1'b0, iack_berr)
    @(posedge sys_clk);
    iack_active <= 1'b0;
    iack_arb_seen <= 1'b0;
    $display("iack test done");
  endtask

  task automatic do_rte(input logic [15:0] special_status_word, input logic rs);
    @(posedge sys_clk);
    rte_req <= 1'b1;
    rte_restart <= rs;
    stacked_frame <= '{special_status_word, 32'h0000_1F2C, 32'h0, 5'h0};
    @(posedge sys_clk);
    rte_req <= 1'b0;
    rte_restart <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic test_rerun;
    logic [31:0] w;
    w = vector_word;
    do_rte(16'h1025, 1'b0);
    expect_req(32'h0000_1F2C, 3'h5, exc_vec_pkg::SIZE_WORD, 1'b1);
    `CHK("write rerun done", 1'b1, rerun_done)
    `CHK("no restart", 1'b0, restart_fetch)
    do_rte(16'h1051, 1'b1);
    expect_req(32'h0000_1F2C, 3'h1, exc_vec_pkg::SIZE_BYTE, 1'b0);
    `CHK("read rerun done", 1'b1, rerun_done)
    `CHK("restart after rerun", 1'b1, restart_fetch)
    `CHK("read not delivered", 1'b0, vector_valid)
    `CHK("read discarded", w, vector_word)
    // every control bit set except rerun-required
    do_rte(16'hEFFF, 1'b0);
    repeat (4)
    begin
      `CHK("no rerun cycle", 1'b0, bus_req.valid)
      `CHK("no rerun done", 1'b0, rerun_done)
      @(negedge sys_clk);
    end
    do_rte(16'h0000, 1'b1);
    `CHK("restart pulse", 1'b1, restart_fetch)
    @(negedge sys_clk);
    `CHK("restart ends", 1'b0, restart_fetch)
    $display("rerun test done");
  endtask

  task automatic test_capture;
    @(posedge sys_clk);
    fault_capture <= 1'b1;
    live_frame <= '{16'h1234, 32'hDEAD_0000, 32'h0000_2468, 5'h0B};
    @(posedge sys_clk);
    fault_capture <= 1'b0;
    @(negedge sys_clk);
    `CHK("saved frame", live_frame, saved_frame)
    `CHK("moved count", 5'h05, 5'(exc_vec_pkg::MOVE_OPERANDS_MAX - saved_frame.move_remaining))
    $display("capture test done");
  endtask

  initial
  begin
    arst_n = 1'b0;
    exc_req = '0;
    iack_active = 1'b0;
    iack_arb_seen = 1'b0;
    rte_req = 1'b0;
    rte_restart = 1'b0;
    stacked_frame = '0;
    fault_capture = 1'b0;
    live_frame = '0;
    lat = 4'h0;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    test_reset;
    test_vectors;
    test_iack;
    test_rerun;
    test_capture;
    finish_test;
  end

  // whole run is well under 2000 cycles
  initial
  begin
    #2000000;
    error_cnt++;
    finish_test;
  end
endmodule // exc_vec_unit_test
